/* rtl/ucs_codec.sv */
// Command decoder and status sender of the transceiver interface.
// Assumes the link shares clk; analog indications arrive unsynchronised.
// Summary of operation
// - Device raises NXT after accepting a command
// - Bits seven to six give command type
// - No-PID transmit starts after next data byte
// - PID transmit takes identifier from bits three-zero
// - Extended write takes a following address byte
// - Other writes use six payload address bits
// - Extended read takes a following address byte
// - Other reads use six payload address bits
// - Status: assert DIR, drive a status byte each cycle while a change is pending
// - Any status field change sends a status byte
// - Line, VBUS and event fields in place
// - Bit six reflects ID after settling
// - Enabled BVALID edges send alternate interrupt bit
// - Line change sends status with new state
// - Peripheral full-speed and high-speed line coding
// - Chirp coding uses differential receiver output
// - Host coding for low, full, high, chirp
// - VBUS field encodes comparator thresholds
// - Event field encodes activity, error, disconnect
// - Receive error drops NXT, sends error status
`timescale 1ns/1ps
module ucs_codec #(
  parameter int ID_SETTLE_CYCLES = ucs_pkg::ID_SETTLE_CYC
) (
  input wire logic clk,               // Interface clock
  input wire logic rst_n,             // Async reset, active low
  input wire logic [7:0] data_in,     // Data bus from link
  output logic [7:0] data_out,        // Data bus to link
  output logic data_oe,               // High while device drives data
  output logic dir,                   // Bus direction, high = to link
  output logic nxt,                   // Next/accept strobe
  input wire logic stp,               // Link stop
  input wire logic dp,                // D+ comparator, async
  input wire logic dm,                // D- comparator, async
  input wire logic squelch,           // HS squelch, async
  input wire logic hs_diff,           // HS differential out, async
  input wire logic sess_end,          // Session end comparator, async
  input wire logic sess_vld,          // Session valid comparator, async
  input wire logic vbus_vld,          // VBUS valid comparator, async
  input wire logic id_pin,            // ID level, async
  input wire logic bvalid,            // B-session valid, async
  input wire logic host_disc,         // Host disconnect, async
  input wire logic [1:0] xcvr_select, // Transceiver select
  input wire logic term_select,       // Termination select
  input wire logic [1:0] opmode,      // Operating mode
  input wire logic dp_pulldown,       // D+ pull-down enabled
  input wire logic dm_pulldown,       // D- pull-down enabled
  input wire logic id_pullup,         // ID pull-up enabled
  input wire logic bvalid_rise_en,    // Alert on BVALID rise
  input wire logic bvalid_fall_en,    // Alert on BVALID fall
  input wire logic rx_active,         // Receiver packet active
  input wire logic rx_error,          // Receiver error
  input wire logic rx_valid,          // Receive byte strobe
  input wire logic [7:0] rx_byte,     // Received byte
  output logic tx_start,              // Start of USB transmit
  output logic tx_nopid,              // Transmit carries no PID
  output logic [3:0] tx_pid,          // Packet identifier
  output logic tx_valid,              // Transmit byte strobe
  output logic [7:0] tx_data,         // Transmit byte
  output logic tx_end,                // End of transmit
  output logic reg_wr,                // Register write strobe
  output logic reg_rd,                // Register read strobe
  output logic [7:0] reg_addr,        // Register address
  output logic [7:0] reg_wdata,       // Register write data
  input wire logic [7:0] reg_rdata    // Register read data
);
  localparam int CW = ucs_pkg::ID_CNT_W;
  localparam logic [CW-1:0] ID_LAST = CW'(ID_SETTLE_CYCLES - 1);

  ucs_pkg::ucs_state_t st;
  ucs_pkg::ucs_state_t next_st;
  logic [ucs_pkg::SI_W-1:0] si;
  logic [1:0] ls;
  logic [1:0] vbus;
  logic [1:0] ev;
  logic [7:0] cur_stat;
  logic [7:0] sent_stat;
  logic stat_pend;
  logic stat_load;
  logic alt_pend;
  logic bvalid_q;
  logic [CW-1:0] id_cnt;
  logic id_ok;
  logic hold;
  logic rx_nxt;
  logic cmd_ok;
  logic [7:0] cmd;
  logic tx_first;
  logic [1:0] cmd_type;
  logic rx_take;

  // ****************************************************
  // Input synchronisation and status fields
  // ****************************************************
  ucs_sync #(.W(ucs_pkg::SI_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({host_disc, bvalid, id_pin, vbus_vld, sess_vld, sess_end,
        hs_diff, squelch, dm, dp}),
    .q(si)
  );

  ucs_line_enc u_line (
    .dp(si[ucs_pkg::SI_DP]),
    .dm(si[ucs_pkg::SI_DM]),
    .squelch(si[ucs_pkg::SI_SQUELCH]),
    .hs_diff(si[ucs_pkg::SI_HS_DIFF]),
    .xcvr_select(xcvr_select),
    .term_select(term_select),
    .opmode(opmode),
    .host_mode(dp_pulldown & dm_pulldown),
    .line_state(ls)
  );

  always_comb begin
    if (si[ucs_pkg::SI_VBUS_VLD]) begin
      vbus = ucs_pkg::VB_VBUS_OK;
    end else if (si[ucs_pkg::SI_SESS_VLD]) begin
      vbus = ucs_pkg::VB_SESS_OK;
    end else if (!si[ucs_pkg::SI_SESS_END]) begin
      vbus = ucs_pkg::VB_ABOVE_END;
    end else begin
      vbus = ucs_pkg::VB_BELOW_END;
    end
  end

  // Disconnect only has meaning as a host
  always_comb begin
    if (dp_pulldown && dm_pulldown && si[ucs_pkg::SI_HOST_DISC]) begin
      ev = ucs_pkg::EV_DISCON;
    end else if (rx_active && rx_error) begin
      ev = ucs_pkg::EV_ERROR;
    end else if (rx_active) begin
      ev = ucs_pkg::EV_ACTIVE;
    end else begin
      ev = ucs_pkg::EV_NONE;
    end
  end

  // ID reads low until the pull-up has settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_cnt <= '0;
      id_ok <= 1'b0;
    end else if (!id_pullup) begin
      id_cnt <= '0;
      id_ok <= 1'b0;
    end else if (id_cnt == ID_LAST) begin
      id_ok <= 1'b1;
    end else begin
      id_cnt <= id_cnt + 1'b1;
    end
  end

  assign cur_stat = {alt_pend, id_ok & si[ucs_pkg::SI_ID], ev, vbus, ls};
  assign stat_pend = (cur_stat[ucs_pkg::ID_BIT:0]
                      != sent_stat[ucs_pkg::ID_BIT:0]) | alt_pend;
  assign rx_take = rx_valid & ~rx_error;
  // Not on the last receive cycle: the byte would never reach the bus
  assign stat_load = (st == ucs_pkg::S_STURN)
                   | ((st == ucs_pkg::S_SDATA) & stat_pend)
                   | ((st == ucs_pkg::S_RX) & rx_active & ~rx_take
                      & stat_pend);

  // ****************************************************
  // Alternate interrupt, set wins over clear
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      alt_pend <= 1'b0;
    end else begin
      bvalid_q <= si[ucs_pkg::SI_BVALID];
      if ((si[ucs_pkg::SI_BVALID] & ~bvalid_q & bvalid_rise_en)
          | (~si[ucs_pkg::SI_BVALID] & bvalid_q & bvalid_fall_en)) begin
        alt_pend <= 1'b1;
      end else if (stat_load) begin
        alt_pend <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Command decode
  // ****************************************************
  assign cmd_type = data_in[ucs_pkg::TYPE_MSB:ucs_pkg::TYPE_LSB];
  // Undefined bytes are ignored rather than guessed at
  assign cmd_ok = (data_in != ucs_pkg::BYTE_IDLE)
                & (cmd_type != ucs_pkg::CMD_IDLE)
                & ((cmd_type != ucs_pkg::CMD_PKT)
                   | (data_in[ucs_pkg::PKT_RSV_MSB:ucs_pkg::PKT_RSV_LSB]
                      == ucs_pkg::PKT_RSV_ZERO));

  always_comb begin
    next_st = st;
    unique case (st)
      ucs_pkg::S_IDLE: begin
        if (rx_active) begin
          next_st = ucs_pkg::S_RXT;
        end else if (stat_pend) begin
          next_st = ucs_pkg::S_STURN;
        end else if (cmd_ok && !hold) begin
          next_st = ucs_pkg::S_CMD;
        end
      end
      ucs_pkg::S_CMD: begin
        if (cmd[ucs_pkg::TYPE_MSB:ucs_pkg::TYPE_LSB] == ucs_pkg::CMD_PKT) begin
          next_st = ucs_pkg::S_TXD;
        end else if (cmd[ucs_pkg::PAY_MSB:0] == ucs_pkg::PAY_EXT) begin
          next_st = ucs_pkg::S_EADDR;
        end else if (cmd[ucs_pkg::TYPE_MSB:ucs_pkg::TYPE_LSB]
                     == ucs_pkg::CMD_REGW) begin
          next_st = ucs_pkg::S_WDATA;
        end else begin
          next_st = ucs_pkg::S_RTURN;
        end
      end
      ucs_pkg::S_TXD: begin
        if (stp) begin
          next_st = ucs_pkg::S_IDLE;
        end
      end
      ucs_pkg::S_EADDR: begin
        next_st = (cmd[ucs_pkg::TYPE_MSB:ucs_pkg::TYPE_LSB]
                   == ucs_pkg::CMD_REGW) ? ucs_pkg::S_WDATA
                                         : ucs_pkg::S_RTURN;
      end
      ucs_pkg::S_WDATA: next_st = ucs_pkg::S_IDLE;
      ucs_pkg::S_RTURN: next_st = ucs_pkg::S_RDATA;
      ucs_pkg::S_RDATA: next_st = ucs_pkg::S_IDLE;
      ucs_pkg::S_STURN: next_st = ucs_pkg::S_SDATA;
      ucs_pkg::S_SDATA: begin
        if (!stat_pend) begin
          next_st = ucs_pkg::S_IDLE;
        end
      end
      ucs_pkg::S_RXT: next_st = ucs_pkg::S_RX;
      ucs_pkg::S_RX: begin
        if (!rx_active) begin
          next_st = ucs_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ucs_pkg::S_IDLE;
      hold <= 1'b0;
    end else begin
      st <= next_st;
      // Link needs a turnaround cycle after release; ignore its bus
      hold <= (next_st == ucs_pkg::S_IDLE) && (st != ucs_pkg::S_IDLE);
    end
  end

  // ****************************************************
  // Bus outputs
  // ****************************************************
  assign dir = st inside {ucs_pkg::S_RTURN, ucs_pkg::S_RDATA,
                          ucs_pkg::S_STURN, ucs_pkg::S_SDATA,
                          ucs_pkg::S_RXT, ucs_pkg::S_RX};
  assign data_oe = st inside {ucs_pkg::S_RDATA, ucs_pkg::S_SDATA,
                              ucs_pkg::S_RX};
  assign nxt = (st inside {ucs_pkg::S_CMD, ucs_pkg::S_TXD,
                           ucs_pkg::S_EADDR, ucs_pkg::S_WDATA})
             | ((st == ucs_pkg::S_RXT) & ~rx_error) | rx_nxt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= ucs_pkg::BYTE_IDLE;
      sent_stat <= ucs_pkg::BYTE_IDLE;
      rx_nxt <= 1'b0;
    end else begin
      rx_nxt <= 1'b0;
      if (st == ucs_pkg::S_RTURN) begin
        data_out <= reg_rdata;
      end else if ((st == ucs_pkg::S_RX) && rx_take) begin
        data_out <= rx_byte;
        rx_nxt <= rx_active;
      end else if (stat_load) begin
        data_out <= cur_stat;
        sent_stat <= cur_stat;
      end
    end
  end

  // ****************************************************
  // Command results to the transmitter and register file
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= ucs_pkg::BYTE_IDLE;
      tx_first <= 1'b0;
      tx_start <= 1'b0;
      tx_nopid <= 1'b0;
      tx_pid <= '0;
      tx_valid <= 1'b0;
      tx_data <= ucs_pkg::BYTE_IDLE;
      tx_end <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ucs_pkg::BYTE_IDLE;
      reg_wdata <= ucs_pkg::BYTE_IDLE;
    end else begin
      tx_start <= 1'b0;
      tx_valid <= 1'b0;
      tx_end <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (st == ucs_pkg::S_IDLE && next_st == ucs_pkg::S_CMD) begin
        cmd <= data_in;
      end
      if (st == ucs_pkg::S_CMD) begin
        reg_addr <= {ucs_pkg::ADDR_PAD, cmd[ucs_pkg::PAY_MSB:0]};
        tx_pid <= cmd[ucs_pkg::PID_MSB:0];
        tx_nopid <= (cmd[ucs_pkg::PAY_MSB:0] == ucs_pkg::PAY_NOPID);
        tx_first <= 1'b1;
        // A PID packet starts at once; no-PID waits for its data
        tx_start <= (cmd[ucs_pkg::TYPE_MSB:ucs_pkg::TYPE_LSB]
                     == ucs_pkg::CMD_PKT)
                  && (cmd[ucs_pkg::PAY_MSB:0] != ucs_pkg::PAY_NOPID);
      end
      if (st == ucs_pkg::S_TXD) begin
        if (stp) begin
          tx_end <= 1'b1;
        end else begin
          tx_valid <= 1'b1;
          tx_data <= data_in;
          tx_first <= 1'b0;
          tx_start <= tx_first && tx_nopid;
        end
      end
      if (st == ucs_pkg::S_EADDR) begin
        reg_addr <= data_in;
      end
      if (st == ucs_pkg::S_WDATA) begin
        reg_wdata <= data_in;
        reg_wr <= 1'b1;
      end
      if (next_st == ucs_pkg::S_RTURN) begin
        reg_rd <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  cmd_accept_a: assert property ((st == ucs_pkg::S_IDLE) && cmd_ok && !hold
      && !rx_active && !stat_pend |=> nxt && !dir)
    else $error("accepted command without NXT");
  imm_addr_a: assert property ((st == ucs_pkg::S_CMD)
      && (cmd[ucs_pkg::PAY_MSB:0] != ucs_pkg::PAY_EXT)
      |=> reg_addr == {ucs_pkg::ADDR_PAD, $past(cmd[ucs_pkg::PAY_MSB:0])})
    else $error("immediate address wrong");
  ext_addr_a: assert property ((st == ucs_pkg::S_EADDR)
      |=> reg_addr == $past(data_in))
    else $error("extended address not taken");
  write_done_a: assert property ((st == ucs_pkg::S_WDATA)
      |=> reg_wr && reg_wdata == $past(data_in) && !dir)
    else $error("write not carried out");
  nopid_start_a: assert property (tx_start && tx_nopid
      |-> $past(st) == ucs_pkg::S_TXD && tx_valid)
    else $error("no-PID transmit started early");
  status_send_a: assert property ((st == ucs_pkg::S_IDLE) && stat_pend
      && !rx_active |=> dir
      ##1 (data_oe && !nxt && data_out == $past(cur_stat)))
    else $error("status change not sent");
  rx_error_a: assert property (rx_active && rx_error
      |=> !nxt)
    else $error("NXT high after receive error");
  alt_bit_a: assert property ($rose(si[ucs_pkg::SI_BVALID]) && bvalid_rise_en
      |=> alt_pend)
    else $error("BVALID rise not flagged");
  read_drive_a: assert property ((st == ucs_pkg::S_RTURN)
      |=> dir && data_oe && data_out == $past(reg_rdata))
    else $error("read data not driven");

  pid_tx_c: cover property ((st == ucs_pkg::S_CMD) ##1 tx_start ##1 tx_valid);
  ext_write_c: cover property ((st == ucs_pkg::S_EADDR) ##2 reg_wr);
  b2b_status_c: cover property ((st == ucs_pkg::S_SDATA) [*2]);
  rx_status_c: cover property ((st == ucs_pkg::S_RX) && data_oe && !nxt);
endmodule // ucs_codec

/* rtl/ucs_line_enc.sv */
// Line state encoder for peripheral and host configurations.
// Assumes synchronised line and receiver levels.
`timescale 1ns/1ps
module ucs_line_enc (
  input wire logic dp,                 // D+ single-ended level
  input wire logic dm,                 // D- single-ended level
  input wire logic squelch,            // High-speed squelch active
  input wire logic hs_diff,            // High-speed differential output
  input wire logic [1:0] xcvr_select,  // Transceiver select
  input wire logic term_select,        // Termination select
  input wire logic [1:0] opmode,       // Operating mode
  input wire logic host_mode,          // Both pull-downs on
  output logic [1:0] line_state        // Encoded line state
);
  logic chirp;

  // Peripheral chirps with termination on, host with chirp op-mode
  assign chirp = host_mode ? (opmode == ucs_pkg::OPMODE_CHIRP)
                           : term_select;

  always_comb begin
    if (xcvr_select == ucs_pkg::XCVR_HS) begin
      if (squelch) begin
        line_state = ucs_pkg::LS_SQUELCH;
      end else if (chirp) begin
        line_state = hs_diff ? ucs_pkg::LS_CHIRP_J
                             : ucs_pkg::LS_CHIRP_K;
      end else begin
        line_state = ucs_pkg::LS_NO_SQUELCH;
      end
    end else begin
      // FS J and LS K are both D+ high, so one mapping serves both
      line_state = {dm, dp};
    end
  end
endmodule // ucs_line_enc

/* rtl/ucs_pkg.sv */
// Package for the transceiver command and status codec.
// Assumes one interface clock at 200 MHz shared with the link.
package ucs_pkg;

  // ****************************************************
  // Transmit command byte
  // ****************************************************
  localparam logic [7:0] BYTE_IDLE = 8'h00;
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_PKT = 2'h1;
  localparam logic [1:0] CMD_REGW = 2'h2;
  localparam logic [1:0] CMD_REGR = 2'h3;
  localparam logic [5:0] PAY_NOPID = 6'h00;
  localparam logic [5:0] PAY_EXT = 6'h2F;
  localparam logic [1:0] PKT_RSV_ZERO = 2'h0;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 6;
  localparam int PAY_MSB = 5;
  localparam int PKT_RSV_MSB = 5;
  localparam int PKT_RSV_LSB = 4;
  localparam int PID_MSB = 3;
  localparam logic [1:0] ADDR_PAD = 2'h0;

  // ****************************************************
  // Status byte fields
  // ****************************************************
  localparam int ALT_BIT = 7;
  localparam int ID_BIT = 6;
  localparam logic [1:0] LS_SQUELCH = 2'h0;
  localparam logic [1:0] LS_NO_SQUELCH = 2'h1;
  localparam logic [1:0] LS_CHIRP_J = 2'h1;
  localparam logic [1:0] LS_CHIRP_K = 2'h2;
  localparam logic [1:0] XCVR_HS = 2'h0;
  localparam logic [1:0] OPMODE_CHIRP = 2'h2;
  localparam logic [1:0] VB_BELOW_END = 2'h0;
  localparam logic [1:0] VB_ABOVE_END = 2'h1;
  localparam logic [1:0] VB_SESS_OK = 2'h2;
  localparam logic [1:0] VB_VBUS_OK = 2'h3;
  localparam logic [1:0] EV_NONE = 2'h0;
  localparam logic [1:0] EV_ACTIVE = 2'h1;
  localparam logic [1:0] EV_DISCON = 2'h2;
  localparam logic [1:0] EV_ERROR = 2'h3;

  // ****************************************************
  // Synchronised analog indications, bit positions
  // ****************************************************
  localparam int SI_DP = 0;
  localparam int SI_DM = 1;
  localparam int SI_SQUELCH = 2;
  localparam int SI_HS_DIFF = 3;
  localparam int SI_SESS_END = 4;
  localparam int SI_SESS_VLD = 5;
  localparam int SI_VBUS_VLD = 6;
  localparam int SI_ID = 7;
  localparam int SI_BVALID = 8;
  localparam int SI_HOST_DISC = 9;
  localparam int SI_W = 10;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int ID_SETTLE_MS = 50;
  localparam int CLK_KHZ = 200000;
  localparam int ID_SETTLE_CYC = ID_SETTLE_MS * CLK_KHZ;
  localparam int ID_CNT_W = 24;

  // ****************************************************
  // Protocol states
  // ****************************************************
  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_CMD   = 11'h002,
    S_TXD   = 11'h004,
    S_EADDR = 11'h008,
    S_WDATA = 11'h010,
    S_RTURN = 11'h020,
    S_RDATA = 11'h040,
    S_STURN = 11'h080,
    S_SDATA = 11'h100,
    S_RXT   = 11'h200,
    S_RX    = 11'h400
  } ucs_state_t;

endpackage

/* rtl/ucs_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module ucs_sync #(
  parameter int W = 1
) (
  input wire logic clk,           // Interface clock
  input wire logic rst_n,         // Async reset, active low
  input wire logic [W-1:0] d,     // Asynchronous levels
  output logic [W-1:0] q          // Synchronised levels
);
  logic [W-1:0] meta;

  // First stage feeds the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // ucs_sync

/* test/test_ulpi_command_status_codec.sv */
// Self-checking bench of the codec with a link model on the data bus.
// Assumes a 200 MHz clock; ID settling shortened to 8 cycles.
`timescale 1ns/1ps
module test_ulpi_command_status_codec;
  logic clk = 0, rst_n = 0, dp = 0, dm = 0, squelch = 1, hs_diff = 0;
  logic sess_end = 0, sess_vld = 0, vbus_vld = 0, id_pin = 0, bvalid = 0;
  logic host_disc = 0, term_select = 1, dp_pulldown = 0, dm_pulldown = 0;
  logic id_pullup = 0, bvalid_rise_en = 0, bvalid_fall_en = 0;
  logic rx_active = 0, rx_error = 0, rx_valid = 0, stp, data_oe, dir, nxt;
  logic tx_start, tx_nopid, tx_valid, tx_end, reg_wr, reg_rd, nop_q, ok;
  logic [1:0] xcvr_select = 2'h1, opmode = 2'h0;
  logic [3:0] tx_pid, pid_q;
  logic [7:0] rx_byte = 8'h00, data_in, data_out, tx_data, reg_addr;
  logic [7:0] reg_wdata, reg_rdata, wa, wd, txd_q, rd;
  logic [31:0] r;
  int fail_count = 0, n_compared = 0, cnt, n_rd = 0, n_end = 0;
  // Rows: command, extended address, data or read data, address or pid
  logic [31:0] cmds [8] = '{32'h85005A05, 32'hBF00A53F, 32'hAFC33CC3,
    32'hC700F807, 32'hEF817E81, 32'hFF00C03F, 32'h4D00B00D, 32'h40001110};
  // Rows: {dp,dm,sq,hsd,se,sv,vv,pd,xcvr,term,opmode,0}, status
  logic [23:0] stat [11] = '{24'hA86001, 24'h606006, 24'hE4600B,
    24'h26600C, 24'h06000D, 24'h06200E, 24'h16200D, 24'h26000C,
    24'hA7A00D, 24'h07100E, 24'h07080D};
  always #2.5 clk = ~clk;
  assign reg_rdata = ~reg_addr;
  ucs_codec #(.ID_SETTLE_CYCLES(8)) uut (.clk, .rst_n, .data_in,
    .data_out, .data_oe, .dir, .nxt, .stp, .dp, .dm, .squelch, .hs_diff,
    .sess_end, .sess_vld, .vbus_vld, .id_pin, .bvalid, .host_disc,
    .xcvr_select, .term_select, .opmode, .dp_pulldown, .dm_pulldown,
    .id_pullup, .bvalid_rise_en, .bvalid_fall_en, .rx_active, .rx_error,
    .rx_valid, .rx_byte, .tx_start, .tx_nopid, .tx_pid, .tx_valid,
    .tx_data, .tx_end, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  ucs_link u_link (.clk, .dir, .nxt, .data_oe, .data_out, .data_in, .stp);
  always @(posedge clk) begin
    if (reg_wr) wa <= reg_addr;
    if (reg_wr) wd <= reg_wdata;
    if (tx_start) pid_q <= tx_pid;
    if (tx_start) nop_q <= tx_nopid;
    if (tx_valid) txd_q <= tx_data;
    if (reg_rd) n_rd <= n_rd + 1;
    if (tx_end) n_end <= n_end + 1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is under 1000 cycles
  initial begin
    #25000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge clk);
    check(8'({dir, nxt, data_oe, reg_wr}), 8'h00);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = cmds[i];
      u_link.access(r[31:24], r[23:16], r[15:8], rd, ok);
      check(8'(ok), 8'h01);
      repeat (3) @(negedge clk);
      case (r[31:30])
        ucs_pkg::CMD_REGW: check(wa, r[7:0]);
        ucs_pkg::CMD_REGR: check(rd, ~r[7:0]);
        default: check(8'({nop_q, pid_q & {4{~nop_q}}}), r[7:0]);
      endcase
      check(r[31] ? (r[30] ? rd : wd) : txd_q, r[15:8]);
    end
    check(8'(n_rd), 8'h03);
    check(8'(n_end), 8'h02);
    for (int i = 0; i < 11; i++) begin
      {dp, dm, squelch, hs_diff, sess_end, sess_vld} = stat[i][23:18];
      {vbus_vld, dp_pulldown, dm_pulldown} = {stat[i][17:16], stat[i][16]};
      {xcvr_select, term_select, opmode} = stat[i][15:11];
      repeat (8) @(negedge clk);
      check(u_link.status, stat[i][7:0]);
    end
    {id_pin, id_pullup} = 2'h3;
    repeat (4) @(negedge clk);
    check(u_link.status, 8'h0D);
    repeat (12) @(negedge clk);
    check(u_link.status, 8'h4D);
    {bvalid_rise_en, bvalid} = 2'h3;
    repeat (8) @(negedge clk);
    check(u_link.status, 8'hCD);
    cnt = u_link.n_status;
    bvalid = 1'b0;
    repeat (8) @(negedge clk);
    check(8'(u_link.n_status - cnt), 8'h00);
    rx_active = 1'b1;
    @(negedge clk);
    check(8'({dir, nxt}), 8'h03);
    @(negedge clk);
    {rx_valid, rx_byte} = 9'h1A5;
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (2) @(negedge clk);
    check(u_link.rxd, 8'hA5);
    rx_error = 1'b1;
    repeat (8) @(negedge clk);
    check(8'(nxt), 8'h00);
    check(u_link.status, 8'h7D);
    {rx_active, rx_error} = 2'h0;
    repeat (8) @(negedge clk);
    check(8'(dir), 8'h00);
    check(u_link.status, 8'h4D);
    host_disc = 1'b1;
    repeat (8) @(negedge clk);
    check(u_link.status, 8'h6D);
    rst_n = 1'b0;
    @(negedge clk);
    check(8'({dir, nxt, data_oe}), 8'h00);
    test_done();
  end
endmodule // test_ulpi_command_status_codec

/* test/ucs_link.sv */
// Link controller model: offers command bytes, takes status bytes.
// Assumes the device answers on clk; the model acts at falling edges.
`timescale 1ns/1ps
module ucs_link (
  input wire logic clk, // Interface clock
  input wire logic dir, // Bus direction
  input wire logic nxt, // Accept strobe
  input wire logic data_oe, // Device drives bus
  input wire logic [7:0] data_out, // Bus from device
  output logic [7:0] data_in, // Bus to device
  output logic stp // Stop strobe
);
  logic [7:0] status;
  logic [7:0] rxd;
  logic rdg;
  int n_status;
  initial begin
    data_in = ucs_pkg::BYTE_IDLE;
    stp = 1'b0;
    rdg = 1'b0;
    n_status = 0;
  end
  // Status is taken in any cycle except during a register read, also inside a packet
  always @(posedge clk) begin
    if (dir && data_oe && !nxt && !rdg) begin
      status <= data_out;
      n_status <= n_status + 1;
    end
    if (dir && data_oe && nxt) rxd <= data_out;
  end
  // Only legal bytes are offered; held until nxt
  task automatic put(input logic [7:0] b, output bit ok);
    int i;
    @(negedge clk);
    data_in = b;
    ok = nxt && !dir;
    for (i = 0; i < 20 && !ok; i++) begin
      @(negedge clk);
      ok = nxt && !dir;
    end
  endtask
  task automatic access(input logic [7:0] c, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] rd, output bit ok);
    bit k;
    int i;
    put(c, ok);
    if (c[7] && c[5:0] == ucs_pkg::PAY_EXT) begin
      put(a, k);
      ok &= k;
    end
    if (c[7:6] != ucs_pkg::CMD_REGR) begin
      put(d, k);
      ok &= k;
      @(negedge clk);
      data_in = ucs_pkg::BYTE_IDLE;
      stp = 1'b1;
      @(negedge clk);
      stp = 1'b0;
    end else begin
      @(negedge clk);
      data_in = ucs_pkg::BYTE_IDLE;
      rdg = 1'b1;
      for (i = 0; i < 8 && !(dir && data_oe); i++) @(negedge clk);
      rd = data_out;
      @(negedge clk);
      rdg = 1'b0;
    end
  endtask
endmodule // ucs_link
